// File: core/mcute_core.sv
// instruction sequencer and execute unit of the 8-bit core
// assumes program and data memory answer within one clock
`timescale 1ns/1ps
`default_nettype none
module mcute_core (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // program memory
  output logic [mcute_pkg::PC_W-1:0] PM_ADDR,
  input wire logic [mcute_pkg::IW-1:0] PM_DATA,
  // data memory
  output logic [7:0] DM_RADDR,
  input wire logic [7:0] DM_RDATA,
  output logic [7:0] DM_WADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  // core state
  output logic [7:0] ACC,
  output logic FLAG_Z,
  output logic FLAG_C,
  output logic [7:0] TBL_HIGH,
  // power and watchdog
  input wire logic WAKE,
  output logic HALTED,
  output logic WDT_CLEAR
);
  localparam int PW = mcute_pkg::PC_W;

  logic [1:0] phase_ff;
  mcute_pkg::mcute_st_e st_ff;
  logic [PW-1:0] pc_ff;
  logic [mcute_pkg::IW-1:0] ir_ff;
  logic ir_valid_ff;
  logic [7:0] acc_ff;
  logic z_ff;
  logic c_ff;
  logic [7:0] tbl_hi_ff;
  logic [7:0] tbl_dst_ff;
  logic [PW-1:0] stk_ff [mcute_pkg::STK_N];
  logic [mcute_pkg::SP_W-1:0] sp_ff;
  logic dm_we_ff;
  logic [7:0] dm_waddr_ff;
  logic [7:0] dm_wdata_ff;
  logic wdt_ff;
  logic wake_s1_ff;
  logic wake_s2_ff;

  logic exec;
  logic ex_ok;
  mcute_pkg::mcute_op_e op;
  logic [2:0] fld;
  logic [7:0] arg;
  logic [PW-1:0] cur_pc;
  logic [7:0] rd;
  logic [7:0] opnd;
  logic isx;
  logic [7:0] mask;
  logic [7:0] res;
  logic [8:0] sum9;
  logic nc;
  logic ci;
  logic dst;
  logic w_acc;
  logic w_mem;
  logic u_z;
  logic u_c;
  logic skip;
  logic jump_unconditional_op;
  logic [PW-1:0] tgt;
  logic push;
  logic pop;
  logic go_tab;
  logic halt;
  logic wdt;
  logic pcl_wr;
  logic chk_ovf;

  // one execute slot per four clocks; see [RULE_03]
  assign exec = phase_ff == mcute_pkg::PH_LAST;
  // a flushed slot executes nothing; see [RULE_17]
  assign ex_ok = exec && st_ff == mcute_pkg::ST_RUN && ir_valid_ff;
  assign op = mcute_pkg::mcute_op_e'(ir_ff[mcute_pkg::OP_MSB:mcute_pkg::OP_LSB]);
  assign fld = ir_ff[mcute_pkg::FLD_MSB:mcute_pkg::FLD_LSB];
  assign arg = ir_ff[mcute_pkg::ARG_MSB:0];
  // pc already points one past the executing word
  assign cur_pc = pc_ff - mcute_pkg::PC_STEP;
  assign rd = (arg == mcute_pkg::PCL_ADDR) ? cur_pc[7:0] : DM_RDATA;
  assign isx = op inside {mcute_pkg::OP_ADDX, mcute_pkg::OP_SUBX,
                          mcute_pkg::OP_ANDX, mcute_pkg::OP_ORX,
                          mcute_pkg::OP_XORX, mcute_pkg::OP_MOVX};
  assign opnd = isx ? arg : rd;
  assign mask = mcute_pkg::ONE8 << fld;
  assign ci = fld[1] & c_ff;
  assign chk_ovf = (9'(acc_ff) + 9'(rd)) > mcute_pkg::BYTE_MAX;

  always_comb begin
    res = mcute_pkg::ZERO8;
    sum9 = 9'h000;
    nc = c_ff;
    dst = 1'b0;
    w_acc = 1'b0;
    w_mem = 1'b0;
    u_z = 1'b0;
    u_c = 1'b0;
    skip = 1'b0;
    jump_unconditional_op = 1'b0;
    tgt = cur_pc;
    push = 1'b0;
    pop = 1'b0;
    go_tab = 1'b0;
    halt = 1'b0;
    wdt = 1'b0;
    pcl_wr = 1'b0;
    case (op)
      mcute_pkg::OP_ADD, mcute_pkg::OP_ADDX: begin
        // carry is the ninth bit; see [RULE_09]
        sum9 = 9'(acc_ff) + 9'(opnd) + 9'(ci);
        res = sum9[7:0];
        nc = sum9[8];
        {u_z, u_c, dst} = 3'h7;
      end
      mcute_pkg::OP_SUB, mcute_pkg::OP_SUBX: begin
        // carry flag holds the borrow; see [RULE_09]
        sum9 = 9'(acc_ff) - 9'(opnd) - 9'(ci);
        res = sum9[7:0];
        nc = sum9[8];
        {u_z, u_c, dst} = 3'h7;
      end
      mcute_pkg::OP_AND, mcute_pkg::OP_ANDX: begin
        res = acc_ff & opnd;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_OR, mcute_pkg::OP_ORX: begin
        res = acc_ff | opnd;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_XOR, mcute_pkg::OP_XORX: begin
        res = acc_ff ^ opnd;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_CPL: begin
        res = ~rd;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_INC: begin
        res = rd + mcute_pkg::ONE8;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_DEC: begin
        res = rd - mcute_pkg::ONE8;
        {u_z, dst} = 2'h3;
      end
      mcute_pkg::OP_ROT: begin
        // fld2 left, fld1 through carry; see [RULE_12]
        u_c = fld[1];
        dst = 1'b1;
        if (fld[2]) begin
          res = {rd[6:0], fld[1] ? c_ff : rd[7]};
          nc = rd[7];
        end else begin
          res = {fld[1] ? c_ff : rd[0], rd[7:1]};
          nc = rd[0];
        end
      end
      mcute_pkg::OP_MOVAM, mcute_pkg::OP_MOVX: begin
        res = opnd;
        w_acc = 1'b1;
      end
      mcute_pkg::OP_MOVMA: begin
        res = acc_ff;
        w_mem = 1'b1;
      end
      mcute_pkg::OP_BSET: begin
        // internal read-modify-write; see [RULE_14]
        res = rd | mask;
        w_mem = 1'b1;
      end
      mcute_pkg::OP_BCLR: begin
        res = rd & ~mask;
        w_mem = 1'b1;
      end
      mcute_pkg::OP_JMP: begin
        jump_unconditional_op = 1'b1;
        tgt = ir_ff[PW-1:0];
      end
      mcute_pkg::OP_CALL: begin
        {jump_unconditional_op, push} = 2'h3;
        tgt = ir_ff[PW-1:0];
      end
      mcute_pkg::OP_RET, mcute_pkg::OP_INTERRUPT_RETURN_OP: begin
        // resume at the saved address; see [RULE_13]
        {jump_unconditional_op, pop} = 2'h3;
        tgt = stk_ff[sp_ff - mcute_pkg::SP_STEP];
        res = arg;
        w_acc = op == mcute_pkg::OP_RET && fld[0];
      end
      mcute_pkg::OP_SKZ: begin
        // byte test, optional inc/dec; see [RULE_07]
        case (fld[2:1])
          mcute_pkg::SKM_INC: res = rd + mcute_pkg::ONE8;
          mcute_pkg::SKM_DEC: res = rd - mcute_pkg::ONE8;
          default: res = rd;
        endcase
        skip = res == mcute_pkg::ZERO8;
        w_acc = fld[0];
        w_mem = !fld[0] && fld[2:1] != mcute_pkg::SKM_PLAIN;
      end
      mcute_pkg::OP_SKBZ: skip = !rd[fld];
      mcute_pkg::OP_SKBNZ: skip = rd[fld];
      mcute_pkg::OP_TABRD: go_tab = 1'b1;
      mcute_pkg::OP_MISC: begin
        // see [RULE_16]
        halt = arg == mcute_pkg::MISC_HALT;
        wdt = arg == mcute_pkg::MISC_WDT;
      end
      default: ;
    endcase
    // fld0 or immediate form sends result to acc; see [RULE_08] [RULE_10]
    if (dst) begin
      w_acc = fld[0] | isx;
      w_mem = !(fld[0] | isx);
    end
    // a result aimed at pc low acts as a jump; see [RULE_05]
    if (w_mem && arg == mcute_pkg::PCL_ADDR) begin
      pcl_wr = 1'b1;
      jump_unconditional_op = 1'b1;
      tgt = {cur_pc[PW-1:8], res};
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + mcute_pkg::PH_STEP;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
    end else begin
      wake_s1_ff <= WAKE;
      wake_s2_ff <= wake_s1_ff;
    end
  end

  // table read borrows the fetch slot, so it stalls one cycle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= mcute_pkg::ST_RUN;
    end else begin
      case (st_ff)
        mcute_pkg::ST_RUN: begin
          if (ex_ok && go_tab) begin
            st_ff <= mcute_pkg::ST_TABLE; // see [RULE_02] [RULE_15]
          end else if (ex_ok && halt) begin
            st_ff <= mcute_pkg::ST_HALT; // see [RULE_16]
          end
        end
        mcute_pkg::ST_TABLE: begin
          if (exec) begin
            st_ff <= mcute_pkg::ST_RUN;
          end
        end
        mcute_pkg::ST_HALT: begin
          if (wake_s2_ff) begin
            st_ff <= mcute_pkg::ST_RUN;
          end
        end
        default: st_ff <= mcute_pkg::ST_RUN;
      endcase
    end
  end

  // fetch overlaps execute; a redirect drops the fetched word
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      pc_ff <= mcute_pkg::RST_PC;
      ir_ff <= 16'h0000;
      ir_valid_ff <= 1'b0;
    end else if (exec && st_ff == mcute_pkg::ST_RUN) begin
      ir_ff <= PM_DATA;
      // see [RULE_01] [RULE_02] [RULE_04] [RULE_06] [RULE_17]
      ir_valid_ff <= !(ex_ok && (jump_unconditional_op || skip));
      pc_ff <= (ex_ok && jump_unconditional_op) ? tgt : pc_ff + mcute_pkg::PC_STEP;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      acc_ff <= mcute_pkg::ZERO8;
      z_ff <= 1'b0;
      c_ff <= 1'b0;
    end else if (ex_ok) begin
      if (w_acc) begin
        acc_ff <= res;
      end
      if (u_z) begin
        z_ff <= res == mcute_pkg::ZERO8; // see [RULE_11]
      end
      if (u_c) begin
        c_ff <= nc; // see [RULE_09] [RULE_12]
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      tbl_hi_ff <= mcute_pkg::ZERO8;
      tbl_dst_ff <= mcute_pkg::ZERO8;
    end else if (ex_ok && go_tab) begin
      tbl_dst_ff <= arg;
    end else if (exec && st_ff == mcute_pkg::ST_TABLE) begin
      tbl_hi_ff <= PM_DATA[15:8]; // see [RULE_15]
    end
  end

  // pc low has no memory cell, so only table-read writes to it reach the bus
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      dm_we_ff <= 1'b0;
      dm_waddr_ff <= mcute_pkg::ZERO8;
      dm_wdata_ff <= mcute_pkg::ZERO8;
    end else if (exec && st_ff == mcute_pkg::ST_TABLE) begin
      dm_we_ff <= 1'b1;
      dm_waddr_ff <= tbl_dst_ff;
      dm_wdata_ff <= PM_DATA[7:0];
    end else begin
      dm_we_ff <= ex_ok && w_mem && !pcl_wr;
      if (ex_ok && w_mem) begin
        dm_waddr_ff <= arg;
        dm_wdata_ff <= res;
      end
    end
  end

  // stack wraps silently when over-pushed
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sp_ff <= '0;
      for (int i = 0; i < mcute_pkg::STK_N; i++) begin
        stk_ff[i] <= mcute_pkg::RST_PC;
      end
    end else if (ex_ok && push) begin
      stk_ff[sp_ff] <= pc_ff; // see [RULE_13]
      sp_ff <= sp_ff + mcute_pkg::SP_STEP;
    end else if (ex_ok && pop) begin
      sp_ff <= sp_ff - mcute_pkg::SP_STEP;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wdt_ff <= 1'b0;
    end else begin
      wdt_ff <= ex_ok && wdt; // see [RULE_16]
    end
  end

  assign PM_ADDR = (st_ff == mcute_pkg::ST_TABLE) ? {pc_ff[PW-1:8], acc_ff} : pc_ff;
  assign DM_RADDR = arg;
  assign DM_WADDR = dm_waddr_ff;
  assign DM_WDATA = dm_wdata_ff;
  assign DM_WE = dm_we_ff;
  assign ACC = acc_ff;
  assign FLAG_Z = z_ff;
  assign FLAG_C = c_ff;
  assign TBL_HIGH = tbl_hi_ff;
  assign HALTED = st_ff == mcute_pkg::ST_HALT;
  assign WDT_CLEAR = wdt_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_gap;
    !exec [*3] ##1 exec;
  endsequence
  sequence s_table;
    st_ff == mcute_pkg::ST_TABLE ##4 st_ff == mcute_pkg::ST_RUN;
  endsequence

  a_exec_spacing: assert property (exec |=> s_gap) // see [RULE_03]
    else $error("execute slot not every four clocks");
  a_single_cycle: assert property (ex_ok && !jump_unconditional_op && !skip && !go_tab && !halt // see [RULE_01]
    |=> ir_valid_ff && st_ff == mcute_pkg::ST_RUN)
    else $error("plain instruction lost a cycle");
  a_jump_flush: assert property (ex_ok && op == mcute_pkg::OP_JMP // see [RULE_02]
    |=> !ir_valid_ff && pc_ff == $past(tgt))
    else $error("jump did not flush or redirect");
  a_table_stall: assert property (ex_ok && go_tab |=> s_table) // see [RULE_15]
    else $error("table read not two cycles");
  a_pcl_redirect: assert property (ex_ok && pcl_wr // see [RULE_04]
    |=> !ir_valid_ff && pc_ff[7:0] == $past(res) && !dm_we_ff)
    else $error("pc low write not a jump");
  a_skip_taken: assert property (ex_ok && skip // see [RULE_06]
    |=> !ir_valid_ff && pc_ff == $past(pc_ff) + mcute_pkg::PC_STEP)
    else $error("taken skip did not drop next");
  a_skip_not: assert property (ex_ok && op == mcute_pkg::OP_SKBNZ && !rd[fld] // see [RULE_07]
    |=> ir_valid_ff)
    else $error("untaken skip dropped next");
  a_add_carry: assert property (ex_ok && op == mcute_pkg::OP_ADD && !fld[1] // see [RULE_09]
    |=> c_ff == $past(chk_ovf))
    else $error("add carry wrong");
  a_zero_flag: assert property (ex_ok && u_z |=> z_ff == ($past(res) == mcute_pkg::ZERO8)) // see [RULE_11]
    else $error("zero flag wrong");
  a_inc_acc: assert property (ex_ok && op == mcute_pkg::OP_INC && fld[0] // see [RULE_10]
    |=> acc_ff == $past(rd) + mcute_pkg::ONE8)
    else $error("increment not by one");
  a_move_imm: assert property (ex_ok && op == mcute_pkg::OP_MOVX |=> acc_ff == $past(arg)) // see [RULE_08]
    else $error("immediate move wrong");
  a_call_save: assert property (ex_ok && op == mcute_pkg::OP_CALL // see [RULE_13]
    |=> stk_ff[$past(sp_ff)] == $past(pc_ff))
    else $error("call did not save return");
  a_bit_set: assert property (ex_ok && op == mcute_pkg::OP_BSET // see [RULE_14]
    |=> dm_we_ff && dm_wdata_ff == ($past(rd) | $past(mask)))
    else $error("bit set altered other bits");
  a_halt_enter: assert property (ex_ok && halt |=> HALTED) // see [RULE_16]
    else $error("halt not entered");
  a_wdt_pulse: assert property (ex_ok && wdt |=> WDT_CLEAR ##1 !WDT_CLEAR) // see [RULE_16]
    else $error("watchdog clear not one pulse");
endmodule : mcute_core
`default_nettype wire

// File: core/mcute_pkg.sv
// constants, opcodes and states of the instruction sequencer
// assumes a 16-bit program word and an 8-bit data memory
// Operation
// [RULE_01] most instructions take one instruction cycle
// [RULE_02] jump, call, returns, table read take two
// [RULE_03] instruction cycle is four system clocks
// [RULE_04] writing program counter low costs one cycle
// [RULE_05] program counter low write jumps to address
// [RULE_06] taken skip costs one extra cycle
// [RULE_07] skip tests byte or bit, bypasses next
// [RULE_08] moves: memory to acc, acc to memory, immediate
// [RULE_09] add carry over 255, subtract borrow below zero
// [RULE_10] increment and decrement by one, either destination
// [RULE_11] logic operations set zero flag on zero
// [RULE_12] rotate one bit, carry variants use carry
// [RULE_13] return resumes after call, call saves address
// [RULE_14] bit set or clear touches one bit
// [RULE_15] table read fetches program memory data
// [RULE_16] halt powers down, watchdog clear instruction
// [RULE_17] discarded fetch has no side effects
package mcute_pkg;
  localparam int PC_W = 11;
  localparam int IW = 16;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 11;
  localparam int FLD_MSB = 10;
  localparam int FLD_LSB = 8;
  localparam int ARG_MSB = 7;
  localparam int STK_N = 8;
  localparam int SP_W = 3;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;
  localparam logic [PC_W-1:0] RST_PC = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam logic [7:0] PCL_ADDR = 8'h02;
  localparam logic [7:0] MISC_HALT = 8'h01;
  localparam logic [7:0] MISC_WDT = 8'h02;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [8:0] BYTE_MAX = 9'h0FF;
  localparam logic [1:0] SKM_PLAIN = 2'h0;
  localparam logic [1:0] SKM_INC = 2'h1;
  localparam logic [1:0] SKM_DEC = 2'h2;
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_AND, OP_ANDX,
    OP_OR, OP_ORX, OP_XOR, OP_XORX, OP_CPL, OP_INC, OP_DEC,
    OP_ROT, OP_MOVAM, OP_MOVMA, OP_MOVX, OP_BSET, OP_BCLR,
    OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_OP, OP_SKZ, OP_SKBZ, OP_SKBNZ,
    OP_TABRD, OP_MISC
  } mcute_op_e;
  typedef enum logic [1:0] {ST_RUN, ST_TABLE, ST_HALT} mcute_st_e;
endpackage : mcute_pkg

// File: sim/mcute_mem_model.sv
// program and data memory seen by the core
// assumes the bench loads pm and dm while reset is held
`timescale 1ns/1ps
`default_nettype none
module mcute_mem_model (
  // clock
  input wire logic CLK_SYS,
  // program memory
  input wire logic [mcute_pkg::PC_W-1:0] PM_ADDR,
  output logic [mcute_pkg::IW-1:0] PM_DATA,
  // data memory
  input wire logic [7:0] DM_RADDR,
  output logic [7:0] DM_RDATA,
  input wire logic [7:0] DM_WADDR,
  input wire logic [7:0] DM_WDATA,
  input wire logic DM_WE
);
  logic [mcute_pkg::IW-1:0] pm [0:2047];
  logic [7:0] dm [0:255];
  // combinational read, table words come from the same array
  assign PM_DATA = pm[PM_ADDR];
  assign DM_RDATA = dm[DM_RADDR];
  // plain always: the bench also preloads dm
  always @(posedge CLK_SYS) begin
    if (DM_WE === 1'b1) begin
      dm[DM_WADDR] <= DM_WDATA;
    end
  end
endmodule : mcute_mem_model
`default_nettype wire

// File: sim/test_mcute_core.sv
// self-checking bench of the instruction sequencer
// assumes mcute_mem_model answers both memories at once
`timescale 1ns/1ps
`default_nettype none
module test_mcute_core;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic WAKE = 1'b0;
  logic [mcute_pkg::PC_W-1:0] PM_ADDR;
  logic [mcute_pkg::IW-1:0] PM_DATA;
  logic [7:0] DM_RADDR, DM_RDATA, DM_WADDR, DM_WDATA, ACC, TBL_HIGH;
  logic DM_WE, FLAG_Z, FLAG_C, HALTED, WDT_CLEAR;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int wdt_cyc = 0;
  int wc[$];
  logic [7:0] wa[$];

  mcute_core u_dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
    .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WADDR(DM_WADDR), .DM_WDATA(DM_WDATA),
    .DM_WE(DM_WE), .ACC(ACC), .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .TBL_HIGH(TBL_HIGH),
    .WAKE(WAKE), .HALTED(HALTED), .WDT_CLEAR(WDT_CLEAR));
  mcute_mem_model u_mem (.CLK_SYS(CLK_SYS), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
    .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WADDR(DM_WADDR), .DM_WDATA(DM_WDATA),
    .DM_WE(DM_WE));

  initial begin
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // edges since reset release: word k of straight code executes at edge 8+4k
  always @(posedge CLK_SYS) begin
    cyc <= RST_B ? cyc + 1 : 0;
  end
  // outputs settle after the edge, so log on the falling edge
  always @(negedge CLK_SYS) begin
    if (RST_B && DM_WE === 1'b1) begin
      wc.push_back(cyc);
      wa.push_back(DM_WADDR);
    end
    if (RST_B && WDT_CLEAR === 1'b1) begin
      wdt_cyc = cyc;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic p(input int i, input mcute_pkg::mcute_op_e op, input logic [2:0] f, input logic [7:0] a);
    u_mem.pm[i] = {op, f, a};
  endtask : p

  task automatic hold();
    @(posedge CLK_SYS);
    #1 RST_B = 1'b0;
    for (int i = 0; i < 2048; i++) begin
      u_mem.pm[i] = 16'h0000;
    end
    for (int i = 0; i < 256; i++) begin
      u_mem.dm[i] = 8'h00;
    end
  endtask : hold

  task automatic go();
    repeat (10) @(posedge CLK_SYS);
    wc.delete();
    wa.delete();
    #1 RST_B = 1'b1;
  endtask : go

  task automatic at(input int n);
    do @(negedge CLK_SYS); while (cyc != n);
  endtask : at

  // writes expected in order, with the edge that executed them
  task automatic chk_w(input int n, input logic [7:0] ea[8], input int ec[8]);
    chk(32'(wa.size()), 32'(n));
    for (int i = 0; i < n; i++) begin
      chk(32'(wa[i]), 32'(ea[i]));
      chk(32'(wc[i]), 32'(ec[i]));
    end
  endtask : chk_w

  task automatic t_flow();
    hold();
    p(0, mcute_pkg::OP_MOVX, 3'h0, 8'h5A);
    p(1, mcute_pkg::OP_MOVMA, 3'h0, 8'h10);
    p(2, mcute_pkg::OP_JMP, 3'h0, 8'h04);
    p(3, mcute_pkg::OP_MOVMA, 3'h0, 8'h1F);
    p(4, mcute_pkg::OP_CALL, 3'h0, 8'h08);
    p(5, mcute_pkg::OP_MOVMA, 3'h0, 8'h11);
    p(8, mcute_pkg::OP_RET, 3'h0, 8'h00);
    p(9, mcute_pkg::OP_MOVMA, 3'h0, 8'h1E);
    go();
    at(48);
    chk_w(2, '{8'h10, 8'h11, 0, 0, 0, 0, 0, 0}, '{12, 40, 0, 0, 0, 0, 0, 0});
    chk(32'(u_mem.dm[8'h11]), 32'h5A);
  endtask : t_flow

  task automatic t_pcl();
    hold();
    p(0, mcute_pkg::OP_MOVX, 3'h0, 8'h06);
    p(1, mcute_pkg::OP_MOVMA, 3'h0, 8'h02);
    p(2, mcute_pkg::OP_MOVMA, 3'h0, 8'h20);
    p(6, mcute_pkg::OP_MOVMA, 3'h0, 8'h21);
    go();
    at(28);
    chk_w(1, '{8'h21, 0, 0, 0, 0, 0, 0, 0}, '{20, 0, 0, 0, 0, 0, 0, 0});
  endtask : t_pcl

  task automatic t_skip();
    hold();
    u_mem.dm[8'h31] = 8'h05;
    u_mem.dm[8'h32] = 8'hFF;
    p(0, mcute_pkg::OP_SKZ, 3'h0, 8'h30);
    p(1, mcute_pkg::OP_MOVMA, 3'h0, 8'h40);
    p(2, mcute_pkg::OP_MOVMA, 3'h0, 8'h41);
    p(3, mcute_pkg::OP_SKZ, 3'h0, 8'h31);
    p(4, mcute_pkg::OP_MOVMA, 3'h0, 8'h42);
    p(5, mcute_pkg::OP_SKBNZ, 3'h2, 8'h31);
    p(6, mcute_pkg::OP_MOVMA, 3'h0, 8'h43);
    p(7, mcute_pkg::OP_MOVMA, 3'h0, 8'h44);
    p(8, mcute_pkg::OP_SKBZ, 3'h1, 8'h31);
    p(9, mcute_pkg::OP_MOVMA, 3'h0, 8'h45);
    p(10, mcute_pkg::OP_MOVMA, 3'h0, 8'h46);
    p(11, mcute_pkg::OP_SKZ, 3'h2, 8'h32);
    p(12, mcute_pkg::OP_MOVMA, 3'h0, 8'h48);
    p(13, mcute_pkg::OP_MOVMA, 3'h0, 8'h47);
    // untaken bit skip, then decrement-to-acc test without skip
    p(14, mcute_pkg::OP_SKBNZ, 3'h1, 8'h31);
    p(15, mcute_pkg::OP_SKZ, 3'h5, 8'h31);
    p(16, mcute_pkg::OP_MOVMA, 3'h0, 8'h49);
    go();
    at(80);
    chk_w(7, '{8'h41, 8'h42, 8'h44, 8'h46, 8'h32, 8'h47, 8'h49, 0}, '{16, 24, 36, 48, 52, 60, 72, 0});
    chk(32'(u_mem.dm[8'h32]), 32'h00);
    chk(32'(u_mem.dm[8'h49]), 32'h04);
    chk(32'(u_mem.dm[8'h31]), 32'h05);
  endtask : t_skip

  task automatic t_alu();
    // {acc, zero, carry} after each word
    logic [9:0] ex[18] = '{10'h3C0, 10'h041, 10'h3FD, 10'h003, 10'h205, 10'h301, 10'h00D,
      10'h003, 10'h003, 10'h003, 10'h003, 10'h0A3, 10'h03D, 10'h003, 10'h3FC, 10'h201,
      10'h1FC, 10'h101};
    hold();
    u_mem.dm[8'h50] = 8'h81;
    u_mem.dm[8'h51] = 8'hFF;
    u_mem.dm[8'h52] = 8'h01;
    u_mem.dm[8'h53] = 8'hA0;
    u_mem.dm[8'h54] = 8'hF0;
    p(0, mcute_pkg::OP_MOVX, 3'h0, 8'hF0);
    p(1, mcute_pkg::OP_ADDX, 3'h0, 8'h20);
    p(2, mcute_pkg::OP_SUBX, 3'h0, 8'h11);
    p(3, mcute_pkg::OP_ANDX, 3'h0, 8'h00);
    p(4, mcute_pkg::OP_ORX, 3'h0, 8'h81);
    p(5, mcute_pkg::OP_ROT, 3'h1, 8'h50);
    p(6, mcute_pkg::OP_ROT, 3'h7, 8'h50);
    p(7, mcute_pkg::OP_INC, 3'h1, 8'h51);
    p(8, mcute_pkg::OP_DEC, 3'h0, 8'h52);
    p(9, mcute_pkg::OP_BSET, 3'h3, 8'h53);
    p(10, mcute_pkg::OP_BCLR, 3'h7, 8'h53);
    p(11, mcute_pkg::OP_MOVAM, 3'h0, 8'h53);
    p(12, mcute_pkg::OP_CPL, 3'h1, 8'h54);
    p(13, mcute_pkg::OP_XORX, 3'h0, 8'h0F);
    // memory-form adds: carry clear, then carry out
    p(14, mcute_pkg::OP_ADD, 3'h1, 8'h51);
    p(15, mcute_pkg::OP_ADD, 3'h1, 8'h50);
    // subtract with borrow in, rotate right through carry
    p(16, mcute_pkg::OP_SUB, 3'h3, 8'h52);
    p(17, mcute_pkg::OP_ROT, 3'h3, 8'h50);
    go();
    for (int k = 0; k < 18; k++) begin
      at(8 + 4 * k);
      chk(32'({ACC, FLAG_Z, FLAG_C}), 32'(ex[k]));
    end
    chk_w(3, '{8'h52, 8'h53, 8'h53, 0, 0, 0, 0, 0}, '{40, 44, 48, 0, 0, 0, 0, 0});
    chk(32'(u_mem.dm[8'h53]), 32'h28);
  endtask : t_alu

  task automatic t_table_halt();
    hold();
    u_mem.pm[11'h020] = 16'h1234;
    p(0, mcute_pkg::OP_MOVX, 3'h0, 8'h20);
    p(1, mcute_pkg::OP_TABRD, 3'h0, 8'h60);
    p(2, mcute_pkg::OP_MISC, 3'h0, 8'h02);
    p(3, mcute_pkg::OP_MISC, 3'h0, 8'h01);
    p(4, mcute_pkg::OP_MOVMA, 3'h0, 8'h61);
    go();
    at(60);
    chk(32'(u_mem.dm[8'h60]), 32'h34);
    chk(32'(TBL_HIGH), 32'h12);
    chk(32'(wdt_cyc), 32'(20));
    chk(32'(HALTED), 32'h1);
    chk(32'(wa.size()), 32'(1));
    @(posedge CLK_SYS);
    #1 WAKE = 1'b1;
    repeat (16) @(negedge CLK_SYS);
    chk(32'(HALTED), 32'h0);
    chk(32'(wa.size()), 32'(2));
    chk(32'(wa[1]), 32'h61);
    #1 WAKE = 1'b0;
  endtask : t_table_halt

  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    t_flow();
    t_pcl();
    t_skip();
    t_alu();
    t_table_halt();
    wrap_up();
  end
  // the tests need under two microseconds, so this only trips on a hang
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule : test_mcute_core
`default_nettype wire
